//--- verilog/serial_port_data_registers.sv
// Receive and transmit data words of one serial port, on two buses
`timescale 1ns/100ps
module serial_port_data_registers
   import sp_data_pkg::*;
#(
   parameter int DADDR_W = DADDR_W_DEF
) (
   input wire logic i_sys_clk, // System clock, 25 MHz
   input wire logic i_resetn, // Synchronous reset, active low
   input wire logic i_pbus_req, // Peripheral bus request, held to ack
   input wire logic i_pbus_wr, // Peripheral bus write when high
   input wire logic [PADDR_W-1:0] i_pbus_addr, // Peripheral bus byte offset
   input wire logic [DATA_W-1:0] i_pbus_wdata, // Peripheral bus write data
   output logic o_pbus_ack, // Peripheral bus answer pulse
   output logic o_pbus_err, // Peripheral bus unmapped offset
   output logic [DATA_W-1:0] o_pbus_rdata, // Peripheral bus read data
   input wire logic i_dbus_req, // DMA bus request, held to ack
   input wire logic i_dbus_wr, // DMA bus write when high
   input wire logic [DADDR_W-1:0] i_dbus_addr, // DMA bus byte address
   input wire logic [DATA_W-1:0] i_dbus_wdata, // DMA bus write data
   output logic o_dbus_ack, // DMA bus answer pulse
   output logic o_dbus_err, // DMA bus misaligned address
   output logic [DATA_W-1:0] o_dbus_rdata, // DMA bus read data
   input wire logic i_rx_load, // Receive buffer stage hands a word
   input wire logic [DATA_W-1:0] i_rx_data, // Word from receive buffer stage
   output logic o_rx_full, // Receive word not yet read
   input wire logic i_tx_take, // Transmit shifter takes the word
   output logic [DATA_W-1:0] o_tx_data, // Word to transmit shifter
   output logic o_tx_empty // Transmit word consumed, room for next
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   // Peripheral bus: only the two data offsets are served here
   function automatic sel_e pbus_sel(input logic [PADDR_W-1:0] addr);
      sel_e s;
      s = SEL_NONE;
      if (addr == RX_WORD_OFF) begin
         s = SEL_RX;
      end else if (addr == TX_WORD_OFF) begin
         s = SEL_TX;
      end
      return s;
   endfunction : pbus_sel

   // DMA bus: every aligned word of a region aliases its register
   function automatic sel_e dbus_sel(input logic [DADDR_W-1:0] addr);
      sel_e s;
      s = SEL_NONE;
      if (addr[1:0] == WORD_ALIGNED) begin
         s = (addr[DADDR_W-1] == DMA_REGION_TX) ? SEL_TX : SEL_RX;
      end
      return s;
   endfunction : dbus_sel

   logic [DATA_W-1:0] rx_word_q;
   logic [DATA_W-1:0] tx_word_q;
   sel_e p_sel;
   sel_e d_sel;
   logic p_cand;
   logic d_take;
   logic p_take;
   logic conflict;
   logic tx_write;

   // Candidates, conflict and fixed priority
   assign p_sel = pbus_sel(i_pbus_addr);
   assign d_sel = dbus_sel(i_dbus_addr);
   assign p_cand = i_pbus_req && !o_pbus_ack;
   assign d_take = i_dbus_req && !o_dbus_ack;
   assign conflict = p_cand && d_take && (p_sel == d_sel) && (p_sel != SEL_NONE);
   assign p_take = p_cand && !conflict;
   assign tx_write = (d_take && i_dbus_wr && d_sel == SEL_TX) ||
                     (p_take && i_pbus_wr && p_sel == SEL_TX);

   ////////////////////////////////////////////////////////////////////////////
   // Data words

   // Receive word: loaded only from the buffer stage, never by a bus
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         rx_word_q <= RX_WORD_RST;
      end else if (i_rx_load) begin
         rx_word_q <= i_rx_data;
      end
   end

   // Transmit word: written from either bus, DMA bus first
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         tx_word_q <= TX_WORD_RST;
      end else if (d_take && i_dbus_wr && d_sel == SEL_TX) begin
         tx_word_q <= i_dbus_wdata;
      end else if (p_take && i_pbus_wr && p_sel == SEL_TX) begin
         tx_word_q <= i_pbus_wdata;
      end
   end

   // Shifter output copy of the transmit word
   assign o_tx_data = tx_word_q;

   ////////////////////////////////////////////////////////////////////////////
   // Flags

   // Receive full: load sets, a bus read of the receive word clears, set wins
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_rx_full <= 1'b0;
      end else if (i_rx_load) begin
         o_rx_full <= 1'b1;
      end else if ((d_take && !i_dbus_wr && d_sel == SEL_RX) ||
                   (p_take && !i_pbus_wr && p_sel == SEL_RX)) begin
         o_rx_full <= 1'b0;
      end
   end

   // Transmit empty: shifter take sets, a bus write of the transmit word clears, set wins
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_tx_empty <= 1'b1;
      end else if (i_tx_take) begin
         o_tx_empty <= 1'b1;
      end else if ((d_take && i_dbus_wr && d_sel == SEL_TX) ||
                   (p_take && i_pbus_wr && p_sel == SEL_TX)) begin
         o_tx_empty <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answers

   // Peripheral bus answer, read data from the data words only
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_pbus_ack <= 1'b0;
         o_pbus_err <= 1'b0;
         o_pbus_rdata <= RDATA_NONE;
      end else begin
         o_pbus_ack <= p_take;
         o_pbus_err <= p_take && (p_sel == SEL_NONE);
         if (p_take && !i_pbus_wr) begin
            unique case (p_sel)
               SEL_RX: o_pbus_rdata <= rx_word_q;
               SEL_TX: o_pbus_rdata <= tx_word_q;
               default: o_pbus_rdata <= RDATA_NONE;
            endcase
         end else begin
            o_pbus_rdata <= RDATA_NONE;
         end
      end
   end

   // DMA bus answer, same data words at every aligned alias
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_dbus_ack <= 1'b0;
         o_dbus_err <= 1'b0;
         o_dbus_rdata <= RDATA_NONE;
      end else begin
         o_dbus_ack <= d_take;
         o_dbus_err <= d_take && (d_sel == SEL_NONE);
         if (d_take && !i_dbus_wr) begin
            unique case (d_sel)
               SEL_RX: o_dbus_rdata <= rx_word_q;
               SEL_TX: o_dbus_rdata <= tx_word_q;
               default: o_dbus_rdata <= RDATA_NONE;
            endcase
         end else begin
            o_dbus_rdata <= RDATA_NONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   // Both buses aim at one register in one cycle
   sequence seq_clash;
      conflict;
   endsequence

   // Peripheral access answered after the DMA one
   sequence seq_pbus_late;
      !o_pbus_ack ##1 o_pbus_ack;
   endsequence

   // A bus write to the receive word leaves it unchanged
   rx_read_only_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      ((d_take && i_dbus_wr && d_sel == SEL_RX) ||
       (p_take && i_pbus_wr && p_sel == SEL_RX)) && !i_rx_load |=> $stable(rx_word_q))
      else $error("receive word changed by a bus write");

   // DMA read of any aligned receive alias returns the receive word
   dma_rx_alias_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      d_take && !i_dbus_wr && d_sel == SEL_RX |=>
         o_dbus_ack && !o_dbus_err && o_dbus_rdata == $past(rx_word_q))
      else $error("DMA receive alias read wrong data");

   // DMA write to any aligned transmit alias reaches the shifter word
   dma_tx_alias_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      i_dbus_req && !o_dbus_ack && i_dbus_wr && i_dbus_addr[1:0] == WORD_ALIGNED &&
         i_dbus_addr[DADDR_W-1] == DMA_REGION_TX |=> o_tx_data == $past(i_dbus_wdata))
      else $error("DMA transmit alias write lost");

   // Peripheral read of the receive offset returns the receive word
   pbus_rx_read_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      p_take && !i_pbus_wr && i_pbus_addr == RX_WORD_OFF |=>
         o_pbus_ack && o_pbus_rdata == $past(rx_word_q))
      else $error("peripheral receive read wrong data");

   // Peripheral write of the transmit offset updates the word, clears empty
   pbus_tx_write_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      p_take && i_pbus_wr && i_pbus_addr == TX_WORD_OFF && !i_tx_take |=>
         o_tx_data == $past(i_pbus_wdata) && !o_tx_empty)
      else $error("peripheral transmit write lost");

   // Clash defers the peripheral access by exactly one cycle
   clash_in_turn_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      seq_clash ##1 i_pbus_req |-> o_dbus_ack ##0 seq_pbus_late)
      else $error("clashing accesses not served in turn");

   // Receive load is flagged and readable next cycle
   rx_load_seen_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      i_rx_load |=> o_rx_full && rx_word_q == $past(i_rx_data))
      else $error("receive load not seen");

   // Unmapped peripheral offset answers error with zero data
   pbus_unmapped_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      p_take && p_sel == SEL_NONE |=> o_pbus_err && o_pbus_rdata == RDATA_NONE)
      else $error("unmapped peripheral offset not flagged");

   // Shifter take marks the transmit word empty
   tx_take_seen_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      i_tx_take |=> o_tx_empty && ($stable(o_tx_data) || $past(tx_write)))
      else $error("transmit take not seen");

endmodule : serial_port_data_registers

//--- verilog/sp_data_pkg.sv
// Constants for the serial port data register pair
package sp_data_pkg;
   // Data path width
   localparam int DATA_W = 32;
   // Peripheral bus offset width within one port block
   localparam int PADDR_W = 6;
   // Peripheral bus byte offsets
   localparam logic [PADDR_W-1:0] RX_WORD_OFF = 6'h00;
   localparam logic [PADDR_W-1:0] TX_WORD_OFF = 6'h04;
   // Default DMA data-port address width, top bit picks the region
   localparam int DADDR_W_DEF = 12;
   // Reset values
   localparam logic [DATA_W-1:0] RX_WORD_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] TX_WORD_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RDATA_NONE = 32'h0000_0000;
   // Region select values on the DMA bus
   localparam logic DMA_REGION_RX = 1'b0;
   localparam logic DMA_REGION_TX = 1'b1;
   // Word alignment bits
   localparam logic [1:0] WORD_ALIGNED = 2'h0;

   // Target of one bus access
   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_RX = 2'b01,
      SEL_TX = 2'b11
   } sel_e;
endpackage : sp_data_pkg

//--- verif/bus_master_model.sv
// Model of the CPU and DMA controller driving both data-register buses
`timescale 1ns/100ps
module bus_master_model
   import sp_data_pkg::*;
#(
   parameter int AW = DADDR_W_DEF
) (
   input wire logic i_sys_clk, // System clock
   output logic o_preq, // Peripheral request
   output logic o_pwr, // Peripheral write
   output logic [PADDR_W-1:0] o_paddr, // Peripheral offset
   output logic [DATA_W-1:0] o_pwd, // Peripheral write data
   input wire logic i_pack, // Peripheral answer
   input wire logic [DATA_W-1:0] i_prd, // Peripheral read data
   output logic o_dreq, // DMA request
   output logic o_dwr, // DMA write
   output logic [AW-1:0] o_daddr, // DMA address
   output logic [DATA_W-1:0] o_dwd, // DMA write data
   input wire logic i_dack, // DMA answer
   input wire logic [DATA_W-1:0] i_drd // DMA read data
);
   // Idle buses at time zero
   initial begin
      o_preq = 1'b0;
      o_pwr = 1'b0;
      o_paddr = '0;
      o_pwd = '0;
      o_dreq = 1'b0;
      o_dwr = 1'b0;
      o_daddr = '0;
      o_dwd = '0;
   end
   // Peripheral cycle, held until the answer edge
   task automatic pcyc(input logic wr, input logic [PADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
      @(posedge i_sys_clk);
      o_preq <= 1'b1;
      o_pwr <= wr;
      o_paddr <= a;
      o_pwd <= wd;
      for (int n = 0; n < 8; n++) begin
         @(posedge i_sys_clk);
         if (i_pack === 1'b1) break;
      end
      rd = i_prd;
      o_preq <= 1'b0;
      o_pwd <= ~wd; // Released data does not keep its value
   endtask : pcyc
   // DMA servicing goes over the data-port bus
   task automatic dcyc(input logic wr, input logic [AW-1:0] a,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
      @(posedge i_sys_clk);
      o_dreq <= 1'b1;
      o_dwr <= wr;
      o_daddr <= a;
      o_dwd <= wd;
      for (int n = 0; n < 8; n++) begin
         @(posedge i_sys_clk);
         if (i_dack === 1'b1) break;
      end
      rd = i_drd;
      o_dreq <= 1'b0;
      o_dwd <= ~wd; // Released data does not keep its value
   endtask : dcyc
endmodule : bus_master_model

//--- verif/testbench.sv
// Self-checking bench for the serial port data register pair
`timescale 1ns/100ps
module testbench;
   import sp_data_pkg::*;
   localparam int AW = 12;
   logic clk, resetn, preq, pwr, pack, perr, dreq, dwr, dack, derr;
   logic rx_load, rx_full, tx_take, tx_empty;
   logic [PADDR_W-1:0] paddr;
   logic [AW-1:0] daddr;
   logic [DATA_W-1:0] pwd, prd, dwd, drd, rx_d, tx_d, seed, rd, rd2, rx_exp, tx_exp;
   int miscompares, total_checks, cycles;

   serial_port_data_registers #(.DADDR_W(AW)) uut (.i_sys_clk(clk), .i_resetn(resetn),
      .i_pbus_req(preq), .i_pbus_wr(pwr), .i_pbus_addr(paddr), .i_pbus_wdata(pwd),
      .o_pbus_ack(pack), .o_pbus_err(perr), .o_pbus_rdata(prd),
      .i_dbus_req(dreq), .i_dbus_wr(dwr), .i_dbus_addr(daddr), .i_dbus_wdata(dwd),
      .o_dbus_ack(dack), .o_dbus_err(derr), .o_dbus_rdata(drd),
      .i_rx_load(rx_load), .i_rx_data(rx_d), .o_rx_full(rx_full),
      .i_tx_take(tx_take), .o_tx_data(tx_d), .o_tx_empty(tx_empty));
   bus_master_model #(.AW(AW)) m (.i_sys_clk(clk), .o_preq(preq), .o_pwr(pwr),
      .o_paddr(paddr), .o_pwd(pwd), .i_pack(pack), .i_prd(prd), .o_dreq(dreq),
      .o_dwr(dwr), .o_daddr(daddr), .o_dwd(dwd), .i_dack(dack), .i_drd(drd));

   // Clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         report_and_stop();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Aligned alias inside one DMA region
   function automatic logic [AW-1:0] alias_of(input logic r, input logic [31:0] s);
      return {r, s[AW-2:2], 2'h0};
   endfunction : alias_of
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t %h %h", $time, got, exp);
      end
   endtask : check
   task automatic report_and_stop();
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      resetn = 1'b0;
      rx_load = 1'b0;
      tx_take = 1'b0;
      rx_d = '0;
      seed = 32'h26;
      miscompares = 0;
      total_checks = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      check({30'h0, rx_full, tx_empty}, 32'h1);
      m.pcyc(1'b0, RX_WORD_OFF, '0, rd);
      check(rd, RX_WORD_RST);
      m.dcyc(1'b0, alias_of(DMA_REGION_TX, seed), '0, rd);
      check(rd, TX_WORD_RST);
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         rx_exp = seed;
         @(posedge clk);
         rx_load <= 1'b1;
         rx_d <= seed;
         @(posedge clk);
         rx_load <= 1'b0;
         seed = lfsr(seed);
         m.pcyc(1'b1, RX_WORD_OFF, seed, rd);
         check({30'h0, pack, perr}, 32'h2);
         m.dcyc(1'b1, alias_of(DMA_REGION_RX, seed), ~seed, rd);
         check({30'h0, dack, derr}, 32'h2);
         check({31'h0, rx_full}, 32'h1);
         m.pcyc(1'b0, RX_WORD_OFF, '0, rd);
         check(rd, rx_exp);
         m.dcyc(1'b0, alias_of(DMA_REGION_RX, lfsr(seed)), '0, rd);
         check(rd, rx_exp);
         check({31'h0, rx_full}, 32'h0);
         seed = lfsr(seed);
         tx_exp = seed;
         m.dcyc(1'b1, alias_of(DMA_REGION_TX, seed), seed, rd);
         check(tx_d, tx_exp);
         m.pcyc(1'b0, TX_WORD_OFF, '0, rd);
         check(rd, tx_exp);
         m.dcyc(1'b0, alias_of(DMA_REGION_TX, ~seed), '0, rd);
         check(rd, tx_exp);
         m.pcyc(1'b1, TX_WORD_OFF, ~seed, rd);
         check(tx_d, ~tx_exp);
         m.pcyc(1'b1, 6'h08, seed, rd);
         check(rd, RDATA_NONE);
         check({30'h0, pack, perr}, 32'h3);
         m.dcyc(1'b0, alias_of(DMA_REGION_RX, seed) | 12'h2, '0, rd);
         check(rd, RDATA_NONE);
         check({30'h0, dack, derr}, 32'h3);
         // Both buses hit one register in the same cycle
         fork
            m.pcyc(1'b1, TX_WORD_OFF, seed ^ 32'h5A5A_5A5A, rd);
            m.dcyc(1'b1, alias_of(DMA_REGION_TX, seed), seed, rd2);
         join
         check(tx_d, seed ^ 32'h5A5A_5A5A);
         check({31'h0, tx_empty}, 32'h0);
         fork
            m.pcyc(1'b0, RX_WORD_OFF, '0, rd);
            m.dcyc(1'b0, alias_of(DMA_REGION_RX, seed), '0, rd2);
         join
         check(rd ^ rd2, 32'h0);
         check(rd2, rx_exp);
         @(posedge clk);
         tx_take <= 1'b1;
         @(posedge clk);
         tx_take <= 1'b0;
         @(posedge clk);
         check({31'h0, tx_empty}, 32'h1);
      end
      report_and_stop();
   end
endmodule : testbench
